// *** common/homing_pkg.sv ***
// constants, method codes and state type for the homing sequencer
// assumes one 25 MHz clock; switch and index inputs already synchronous
// Behaviour
// - method 2: start positive if positive limit clear
// - method 2: first index after positive limit releases
// - methods 7 to 10 start positive
// - switch already active: direction from required edge
// - index on rising or falling switch side
// - reverse when limit ahead asserts
// - methods 11 to 14: negative start, limit
// - method 24: like 8, no index
// - method 28: like 12, no index
// - methods 33, 34 home on index only
// - method 35: current position is home, no motion
// - method 35 runs without operation enabled
// - method 1: start negative, index after release
// - index is encoder once-per-turn zero pulse
package homing_pkg;

    localparam int POS_W    = 32;                 // position word width
    localparam int METHOD_W = 8;                  // method code width
    localparam int EDGE_SEL_BIT = 0;              // even code takes rising side

    // method codes as the master writes them
    localparam logic [METHOD_W-1:0] M_NEG_LIM      = 8'h01;
    localparam logic [METHOD_W-1:0] M_POS_LIM      = 8'h02;
    localparam logic [METHOD_W-1:0] M_SW_POS_FIRST = 8'h07;
    localparam logic [METHOD_W-1:0] M_SW_POS_LAST  = 8'h0A;
    localparam logic [METHOD_W-1:0] M_SW_NEG_FIRST = 8'h0B;
    localparam logic [METHOD_W-1:0] M_SW_NEG_LAST  = 8'h0E;
    localparam logic [METHOD_W-1:0] M_SW_POS_NOIDX = 8'h18;
    localparam logic [METHOD_W-1:0] M_SW_NEG_NOIDX = 8'h1C;
    localparam logic [METHOD_W-1:0] M_IDX_NEG      = 8'h21;
    localparam logic [METHOD_W-1:0] M_IDX_POS      = 8'h22;
    localparam logic [METHOD_W-1:0] M_HERE         = 8'h23;

    // direction encoding of the direction flop
    localparam logic DIR_POS = 1'b1;
    localparam logic DIR_NEG = 1'b0;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,      // waiting for a start
        ST_SEEK_LIM,  // driving toward the method's limit
        ST_LEAVE_LIM, // backing off until the limit releases
        ST_EXIT_SW,   // leaving an already active home switch
        ST_SEEK_SW,   // hunting the required home switch edge
        ST_ARM_IDX    // waiting for the next index pulse
    } hstate_e;

endpackage : homing_pkg

// *** core/edge_watch.sv ***
// one-input edge detector giving rise and fall pulses
// assumes the level is already synchronous to the clock
`timescale 1ns/1ps
module edge_watch (
    input  wire logic clk_in,    // system clock
    input  wire logic rst_in,    // async reset, active high
    input  wire logic level_in,  // watched level
    output logic      rise_out,  // low to high this cycle
    output logic      fall_out   // high to low this cycle
);
    logic prev_r;    // level one cycle ago
    logic prev_nxt;  // next value of prev_r

    // previous level and edge terms
    always_comb begin
        prev_nxt = level_in;
        rise_out = level_in & ~prev_r;
        fall_out = ~level_in & prev_r;
    end

    // register the level; reset to low, so a level high at release looks like a rise
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
endmodule : edge_watch

// *** core/homing_sequencer.sv ***
// homing sequencer: picks direction, reverses at limits, captures home
// assumes inputs synchronous to SYS_CLK_IN; motion itself is done elsewhere
`timescale 1ns/1ps
module homing_sequencer
    import homing_pkg::*;
(
    input  wire logic                SYS_CLK_IN,   // 25 MHz system clock
    input  wire logic                RST_IN,       // async reset, active high
    input  wire logic                START_IN,     // one-cycle start request
    input  wire logic [METHOD_W-1:0] METHOD_IN,    // selected homing method
    input  wire logic                OP_ENABLED_IN,// drive in operation enabled
    input  wire logic                POS_LIMIT_IN, // positive_travel_limit, high active
    input  wire logic                NEG_LIMIT_IN, // negative_travel_limit, high active
    input  wire logic                HOME_SW_IN,   // home switch, high active
    input  wire logic                INDEX_IN,     // encoder zero pulse
    input  wire logic [POS_W-1:0]    POSITION_IN,  // present position
    output logic                     MOVE_POS_OUT, // command motion positive
    output logic                     MOVE_NEG_OUT, // command motion negative
    output logic                     BUSY_OUT,     // homing in progress
    output logic                     DONE_OUT,     // homing completed
    output logic                     ERROR_OUT,    // refused or aborted
    output logic                     LOAD_REF_OUT, // one-cycle reference load
    output logic [POS_W-1:0]         HOME_POS_OUT  // captured home position
);

    ////////////////////////////////////////////////////////////////////////
    // edge detection of switches and index

    logic home_rise;   // home switch became active
    logic home_fall;   // home switch became inactive
    logic pos_fall;    // positive limit released
    logic neg_fall;    // negative limit released
    logic idx_rise;    // leading edge of the index pulse

    edge_watch u_home (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (RST_IN),
        .level_in (HOME_SW_IN),
        .rise_out (home_rise),
        .fall_out (home_fall)
    );

    edge_watch u_pos (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (RST_IN),
        .level_in (POS_LIMIT_IN),
        .rise_out (),
        .fall_out (pos_fall)
    );

    edge_watch u_neg (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (RST_IN),
        .level_in (NEG_LIMIT_IN),
        .rise_out (),
        .fall_out (neg_fall)
    );

    // the index input is the encoder's once-per-turn zero pulse
    edge_watch u_idx (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (RST_IN),
        .level_in (INDEX_IN),
        .rise_out (idx_rise),
        .fall_out ()
    );

    ////////////////////////////////////////////////////////////////////////
    // method decode

    logic m_lim;      // methods 1 and 2
    logic m_sw;       // switch methods 7..14, 24, 28
    logic m_sw_neg;   // switch methods starting negative
    logic m_noidx;    // switch methods without index
    logic m_idx;      // index only methods
    logic m_here;     // current position method
    logic m_rise;     // required edge is the rising side

    // decode the method code on the input
    always_comb begin
        m_lim    = (METHOD_IN == M_NEG_LIM) | (METHOD_IN == M_POS_LIM);
        m_noidx  = (METHOD_IN == M_SW_POS_NOIDX) | (METHOD_IN == M_SW_NEG_NOIDX);
        m_sw_neg = ((METHOD_IN >= M_SW_NEG_FIRST) & (METHOD_IN <= M_SW_NEG_LAST))
                 | (METHOD_IN == M_SW_NEG_NOIDX);
        m_sw     = ((METHOD_IN >= M_SW_POS_FIRST) & (METHOD_IN <= M_SW_POS_LAST))
                 | m_sw_neg | m_noidx;
        m_idx    = (METHOD_IN == M_IDX_NEG) | (METHOD_IN == M_IDX_POS);
        m_here   = (METHOD_IN == M_HERE);
        // even codes index on the rising side, odd on the falling side
        m_rise   = ~METHOD_IN[EDGE_SEL_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer state

    hstate_e          state_r, state_nxt;    // sequencer state
    logic             dir_r, dir_nxt;        // present direction
    logic             rise_r, rise_nxt;      // method wants rising side
    logic             noidx_r, noidx_nxt;    // capture on switch edge
    logic             limneg_r, limneg_nxt;  // limit method uses negative limit
    logic             pos_r, pos_nxt;        // motion positive flop
    logic             neg_r, neg_nxt;        // motion negative flop
    logic             busy_r, busy_nxt;      // busy flop
    logic             done_r, done_nxt;      // done flop
    logic             err_r, err_nxt;        // error flop
    logic             load_r, load_nxt;      // reference load strobe
    logic [POS_W-1:0] home_r, home_nxt;      // captured home

    logic lim_ahead;   // limit in the present direction is asserted
    logic sw_edge;     // required home switch edge seen
    logic lim_rel;     // the limit method's limit released
    logic capture;     // take the home point this cycle

    // next-value logic of the whole sequencer
    always_comb begin
        state_nxt  = state_r;
        dir_nxt    = dir_r;
        rise_nxt   = rise_r;
        noidx_nxt  = noidx_r;
        limneg_nxt = limneg_r;
        done_nxt   = done_r;
        err_nxt    = err_r;
        home_nxt   = home_r;
        capture    = 1'b0;
        lim_ahead  = (dir_r == DIR_POS) ? POS_LIMIT_IN : NEG_LIMIT_IN;
        sw_edge    = rise_r ? home_rise : home_fall;
        lim_rel    = limneg_r ? neg_fall : pos_fall;

        unique case (state_r)
            ST_IDLE: begin
                if (START_IN) begin
                    // a new start clears the previous outcome
                    done_nxt  = 1'b0;
                    err_nxt   = 1'b0;
                    rise_nxt  = m_rise;
                    noidx_nxt = m_noidx;
                    if (m_here) begin
                        // no motion, and operation enabled not required
                        capture = 1'b1;
                    end else if (!OP_ENABLED_IN) begin
                        err_nxt = 1'b1;   // motion methods need the drive enabled
                    end else if (m_lim) begin
                        limneg_nxt = (METHOD_IN == M_NEG_LIM);
                        if (METHOD_IN == M_NEG_LIM) begin
                            // toward the negative limit unless already on it
                            dir_nxt   = NEG_LIMIT_IN ? DIR_POS : DIR_NEG;
                            state_nxt = NEG_LIMIT_IN ? ST_LEAVE_LIM : ST_SEEK_LIM;
                        end else begin
                            // toward the positive limit unless already on it
                            dir_nxt   = POS_LIMIT_IN ? DIR_NEG : DIR_POS;
                            state_nxt = POS_LIMIT_IN ? ST_LEAVE_LIM : ST_SEEK_LIM;
                        end
                    end else if (m_sw) begin
                        if (HOME_SW_IN && m_rise) begin
                            // must come back onto the switch: leave it first
                            dir_nxt   = m_sw_neg ? DIR_POS : DIR_NEG;
                            state_nxt = ST_EXIT_SW;
                        end else begin
                            // nominal start direction of the method
                            dir_nxt   = m_sw_neg ? DIR_NEG : DIR_POS;
                            state_nxt = ST_SEEK_SW;
                        end
                    end else if (m_idx) begin
                        // index only, no switch is looked at
                        dir_nxt   = (METHOD_IN == M_IDX_POS) ? DIR_POS : DIR_NEG;
                        state_nxt = ST_ARM_IDX;
                    end else begin
                        err_nxt = 1'b1;   // code 0 and unsupported codes
                    end
                end
            end
            ST_SEEK_LIM: begin
                // run into the limit, then turn back off it
                if (lim_ahead) begin
                    dir_nxt   = ~dir_r;
                    state_nxt = ST_LEAVE_LIM;
                end
            end
            ST_LEAVE_LIM: begin
                // arm on the limit's release edge
                if (lim_rel) begin
                    state_nxt = ST_ARM_IDX;
                end
            end
            ST_EXIT_SW: begin
                if (home_fall) begin
                    // off the switch: turn and approach its rising edge
                    dir_nxt   = ~dir_r;
                    state_nxt = ST_SEEK_SW;
                end else if (lim_ahead) begin
                    dir_nxt = ~dir_r;
                end
            end
            ST_SEEK_SW: begin
                if (sw_edge) begin
                    if (noidx_r) begin
                        capture = 1'b1;
                    end else begin
                        state_nxt = ST_ARM_IDX;
                    end
                end else if (lim_ahead) begin
                    // travelling away from the switch: turn at the limit
                    dir_nxt = ~dir_r;
                end
            end
            ST_ARM_IDX: begin
                if (idx_rise) begin
                    capture = 1'b1;
                end else if (lim_ahead) begin
                    dir_nxt = ~dir_r;
                end
            end
        endcase

        // losing operation enabled mid-run aborts the search
        if ((state_r != ST_IDLE) && !OP_ENABLED_IN) begin
            state_nxt = ST_IDLE;
            err_nxt   = 1'b1;
            capture   = 1'b0;
        end

        // capture loads the reference and reports completion
        if (capture) begin
            state_nxt = ST_IDLE;
            home_nxt  = POSITION_IN;
            done_nxt  = 1'b1;
        end
        load_nxt = capture;
        busy_nxt = (state_nxt != ST_IDLE);
        pos_nxt  = busy_nxt & (dir_nxt == DIR_POS);
        neg_nxt  = busy_nxt & (dir_nxt == DIR_NEG);
    end

    // register every piece of sequencer state
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_r  <= ST_IDLE;
            dir_r    <= DIR_POS;
            rise_r   <= 1'b0;
            noidx_r  <= 1'b0;
            limneg_r <= 1'b0;
            pos_r    <= 1'b0;
            neg_r    <= 1'b0;
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            err_r    <= 1'b0;
            load_r   <= 1'b0;
            home_r   <= '0;
        end else begin
            state_r  <= state_nxt;
            dir_r    <= dir_nxt;
            rise_r   <= rise_nxt;
            noidx_r  <= noidx_nxt;
            limneg_r <= limneg_nxt;
            pos_r    <= pos_nxt;
            neg_r    <= neg_nxt;
            busy_r   <= busy_nxt;
            done_r   <= done_nxt;
            err_r    <= err_nxt;
            load_r   <= load_nxt;
            home_r   <= home_nxt;
        end
    end

    // outputs straight from flops
    assign MOVE_POS_OUT = pos_r;
    assign MOVE_NEG_OUT = neg_r;
    assign BUSY_OUT     = busy_r;
    assign DONE_OUT     = done_r;
    assign ERROR_OUT    = err_r;
    assign LOAD_REF_OUT = load_r;
    assign HOME_POS_OUT = home_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic go;   // accepted start with the drive enabled
    assign go = START_IN && (state_r == ST_IDLE) && OP_ENABLED_IN;

    property p_here;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        START_IN && (state_r == ST_IDLE) && (METHOD_IN == M_HERE)
        |=> LOAD_REF_OUT && (HOME_POS_OUT == $past(POSITION_IN)) && !BUSY_OUT;
    endproperty
    a_here: assert property (p_here)
        else $error("current position method did not capture at once");

    property p_here_off;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        START_IN && (state_r == ST_IDLE) && (METHOD_IN == M_HERE) && !OP_ENABLED_IN
        |=> DONE_OUT && !ERROR_OUT;
    endproperty
    a_here_off: assert property (p_here_off)
        else $error("current position method refused while not enabled");

    property p_m2_start;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        go && (METHOD_IN == M_POS_LIM) && !POS_LIMIT_IN |=> MOVE_POS_OUT && !MOVE_NEG_OUT;
    endproperty
    a_m2_start: assert property (p_m2_start)
        else $error("method 2 did not start positive");

    property p_m1_start;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        go && (METHOD_IN == M_NEG_LIM) && !NEG_LIMIT_IN |=> MOVE_NEG_OUT && !MOVE_POS_OUT;
    endproperty
    a_m1_start: assert property (p_m1_start)
        else $error("method 1 did not start negative");

    property p_sw_pos;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        go && (METHOD_IN >= M_SW_POS_FIRST) && (METHOD_IN <= M_SW_POS_LAST) && !HOME_SW_IN
        |=> MOVE_POS_OUT;
    endproperty
    a_sw_pos: assert property (p_sw_pos)
        else $error("switch method did not start positive");

    property p_sw_neg;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        go && (METHOD_IN >= M_SW_NEG_FIRST) && (METHOD_IN <= M_SW_NEG_LAST) && !HOME_SW_IN
        |=> MOVE_NEG_OUT;
    endproperty
    a_sw_neg: assert property (p_sw_neg)
        else $error("switch method did not start negative");

    property p_on_sw;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        go && (METHOD_IN == M_SW_POS_FIRST + 8'h01) && HOME_SW_IN |=> MOVE_NEG_OUT;
    endproperty
    a_on_sw: assert property (p_on_sw)
        else $error("rising side method on active switch did not leave it");

    property p_turn;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state_r == ST_SEEK_SW) && MOVE_POS_OUT && POS_LIMIT_IN && !sw_edge
        && OP_ENABLED_IN |=> MOVE_NEG_OUT;
    endproperty
    a_turn: assert property (p_turn)
        else $error("no reversal at the limit ahead");

    property p_idx_cap;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state_r == ST_ARM_IDX) && INDEX_IN && !$past(INDEX_IN) && OP_ENABLED_IN
        |=> LOAD_REF_OUT && (HOME_POS_OUT == $past(POSITION_IN));
    endproperty
    a_idx_cap: assert property (p_idx_cap)
        else $error("index edge did not capture home");

    property p_noidx;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state_r == ST_SEEK_SW) && noidx_r && sw_edge && OP_ENABLED_IN |=> LOAD_REF_OUT;
    endproperty
    a_noidx: assert property (p_noidx)
        else $error("switch only method did not capture on edge");

    property p_done;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        LOAD_REF_OUT |-> DONE_OUT && !BUSY_OUT && !MOVE_POS_OUT && !MOVE_NEG_OUT
        ##1 (!LOAD_REF_OUT || $past(START_IN)); // back-to-back method 35 pulses again
    endproperty
    a_done: assert property (p_done)
        else $error("completion not reported with the reference load");

endmodule : homing_sequencer

// *** bench/axis_model.sv ***
// axis stand-in: position counter, travel limits, home switch, zero pulse
// assumes move commands come from flops on the same clock
`timescale 1ns/1ps
module axis_model
    import homing_pkg::*;
#(
    parameter int LIM_AT  = 200, // travel limits at plus and minus this
    parameter int HOME_AT = 100  // home switch active at and above
) (
    input  wire logic             clk_in,       // system clock
    input  wire logic             rst_in,       // async reset, active high
    input  wire logic             move_pos_in,  // step up each cycle
    input  wire logic             move_neg_in,  // step down each cycle
    input  wire logic             load_in,      // preset position
    input  wire logic [POS_W-1:0] load_val_in,  // preset value
    output logic                  pos_lim_out,  // positive_travel_limit
    output logic                  neg_lim_out,  // negative_travel_limit
    output logic                  home_sw_out,  // home switch level
    output logic                  index_out,    // zero pulse
    output logic [POS_W-1:0]      position_out  // present position
);
    logic signed [POS_W-1:0] pos_r; // one count a cycle, no inertia

    ////////////////////////////////////////////////////////////////////////////
    // position follows commands; preset wins over motion
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_r <= '0;
        end else if (load_in) begin
            pos_r <= load_val_in;
        end else if (move_pos_in) begin
            pos_r <= pos_r + 1;
        end else if (move_neg_in) begin
            pos_r <= pos_r - 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switches decoded from position, so they never disagree with it
    assign pos_lim_out  = (pos_r >= LIM_AT);
    assign neg_lim_out  = (pos_r <= -LIM_AT);
    assign home_sw_out  = (pos_r >= HOME_AT);
    assign index_out    = (pos_r[3:0] == 4'h5); // once per 16 counts
    assign position_out = pos_r;
endmodule : axis_model

// *** bench/tb.sv ***
// self-checking bench for the homing sequencer against the axis stand-in
// assumes one 25 MHz clock; inputs change by nonblocking at rising edges
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t value mismatch got %0h exp %0h", $time, a, b); end end
module tb
    import homing_pkg::*;
;
    logic             clk;       // system clock
    logic             rst;       // reset, active high
    logic             start;     // start pulse
    logic [METHOD_W-1:0] meth;   // method code
    logic             op_en;     // operation enabled
    logic             ld;        // axis preset strobe
    logic [POS_W-1:0] ld_val;    // axis preset value
    logic             plim, nlim, hsw, idx, mpos, mneg, busy, done, err, ldref;
    logic [POS_W-1:0] pos, home;
    int               err_count; // mismatches
    int               checks;    // comparisons

    homing_sequencer DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .START_IN(start),
        .METHOD_IN(meth), .OP_ENABLED_IN(op_en), .POS_LIMIT_IN(plim),
        .NEG_LIMIT_IN(nlim), .HOME_SW_IN(hsw), .INDEX_IN(idx), .POSITION_IN(pos),
        .MOVE_POS_OUT(mpos), .MOVE_NEG_OUT(mneg), .BUSY_OUT(busy), .DONE_OUT(done),
        .ERROR_OUT(err), .LOAD_REF_OUT(ldref), .HOME_POS_OUT(home));
    axis_model axis (.clk_in(clk), .rst_in(rst), .move_pos_in(mpos),
        .move_neg_in(mneg), .load_in(ld), .load_val_in(ld_val), .pos_lim_out(plim),
        .neg_lim_out(nlim), .home_sw_out(hsw), .index_out(idx), .position_out(pos));

    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run, shared by main sequence and watchdog
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // preset axis, pulse start, report first direction and captured home
    task automatic run_home(input logic [METHOD_W-1:0] m, input logic [POS_W-1:0] p0,
                            output logic first_pos, output logic [POS_W-1:0] hp);
        int n;
        n = 0;
        @(posedge clk);
        ld <= 1'b1;
        ld_val <= p0;
        @(posedge clk);
        ld <= 1'b0;
        repeat (2) @(posedge clk);
        start <= 1'b1;
        meth <= m;
        @(posedge clk);
        start <= 1'b0;
        #1;
        first_pos = mpos;
        `CHK(busy, 1'b1)
        while (ldref !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        hp = home;
        `CHK(done & ~busy & ~mpos & ~mneg, 1'b1)
        @(posedge clk);
        #1;
        `CHK(ldref, 1'b0)
    endtask : run_home

    ////////////////////////////////////////////////////////////////////////////
    // current position becomes home at once, drive not enabled
    task automatic t_here;
        @(posedge clk);
        op_en <= 1'b0;
        ld <= 1'b1;
        ld_val <= 32'h0000_1234;
        @(posedge clk);
        ld <= 1'b0;
        start <= 1'b1;
        meth <= M_HERE;
        @(posedge clk);
        start <= 1'b0;
        #1;
        `CHK({ldref, done, mpos, mneg, err}, 5'h18)
        `CHK(home, 32'h0000_1234)
        @(posedge clk);
        op_en <= 1'b1;
        $display("test here done");
    endtask : t_here

    // limit methods: toward limit, reverse, first index after release
    task automatic t_limit;
        logic d;
        logic [POS_W-1:0] h;
        run_home(M_POS_LIM, '0, d, h);
        `CHK(d, 1'b1)
        `CHK(h, 32'd197)
        run_home(M_NEG_LIM, '0, d, h);
        `CHK(d, 1'b0)
        `CHK(h, POS_W'(-187))
        $display("test limit done");
    endtask : t_limit

    // index only: first zero pulse in the chosen direction
    task automatic t_index;
        logic d;
        logic [POS_W-1:0] h;
        run_home(M_IDX_POS, '0, d, h);
        `CHK({d, h}, {1'b1, 32'd5})
        run_home(M_IDX_NEG, '0, d, h);
        `CHK({d, h}, {1'b0, POS_W'(-11)})
        $display("test index done");
    endtask : t_index

    // switch plus index, both sides and both start directions
    task automatic t_sw_index;
        logic d;
        logic [POS_W-1:0] h;
        run_home(8'h08, '0, d, h);
        `CHK({d, h}, {1'b1, 32'd101})
        run_home(8'h07, 32'd150, d, h);
        `CHK({d, h}, {1'b1, 32'd85})
        run_home(8'h0C, '0, d, h);
        `CHK({d, h}, {1'b0, 32'd101})
        // rising side wanted while already on the switch: back off, return
        run_home(8'h08, 32'd150, d, h);
        `CHK({d, h}, {1'b0, 32'd101})
        // negative start, falling side: both limits met before the edge
        run_home(8'h0B, '0, d, h);
        `CHK({d, h}, {1'b0, 32'd85})
        $display("test switch index done");
    endtask : t_sw_index

    // switch edge alone sets home, index ignored
    task automatic t_sw_only;
        logic d;
        logic [POS_W-1:0] h;
        run_home(M_SW_POS_NOIDX, '0, d, h);
        `CHK({d, h}, {1'b1, 32'd100})
        run_home(M_SW_POS_NOIDX, 32'd150, d, h);
        `CHK({d, h}, {1'b0, 32'd100})
        run_home(M_SW_NEG_NOIDX, '0, d, h);
        `CHK({d, h}, {1'b0, 32'd100})
        $display("test switch only done");
    endtask : t_sw_only

    // no method and disabled drive are refused without motion
    task automatic t_refuse;
        @(posedge clk);
        start <= 1'b1;
        meth <= 8'h00;
        @(posedge clk);
        start <= 1'b0;
        #1;
        `CHK({err, busy, mpos, mneg, done}, 5'h10)
        @(posedge clk);
        op_en <= 1'b0;
        start <= 1'b1;
        meth <= M_POS_LIM;
        @(posedge clk);
        start <= 1'b0;
        #1;
        `CHK({err, busy, mpos, mneg, done}, 5'h10)
        @(posedge clk);
        op_en <= 1'b1;
        // losing operation enabled mid-search aborts without completion
        @(posedge clk);
        start <= 1'b1;
        meth <= M_IDX_POS;
        @(posedge clk);
        start <= 1'b0;
        op_en <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({err, busy, mpos, mneg, done}, 5'h10)
        @(posedge clk);
        op_en <= 1'b1;
        $display("test refuse done");
    endtask : t_refuse

    ////////////////////////////////////////////////////////////////////////////
    // clock, reset, main sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        err_count = 0;
        checks = 0;
        rst = 1'b1;
        start = 1'b0;
        meth = '0;
        op_en = 1'b1;
        ld = 1'b0;
        ld_val = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_here();
        t_limit();
        t_index();
        t_sw_index();
        t_sw_only();
        t_refuse();
        end_of_test();
    end

    // whole run needs well under 10000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        end_of_test();
    end
endmodule : tb
